// [logic/atmi_defs.svh]
// Constants for the attenuator module two-wire host controller.
// Assumes a 40 MHz system clock and a standard-mode bus with pull-ups.
`ifndef ATMI_DEFS_SVH
`define ATMI_DEFS_SVH

// Clock and bus timing
`define ATMI_CLK_PERIOD_NS 25
`define ATMI_SCL_PERIOD_NS 10000
`define ATMI_BUS_FREE_NS 4700
`define ATMI_QUARTER_CYC ((`ATMI_SCL_PERIOD_NS + 4 * `ATMI_CLK_PERIOD_NS - 1) / (4 * `ATMI_CLK_PERIOD_NS))
`define ATMI_BUS_FREE_CYC ((`ATMI_BUS_FREE_NS + `ATMI_CLK_PERIOD_NS - 1) / `ATMI_CLK_PERIOD_NS)

// Slave address layout
`define ATMI_ADDR_UPPER 4'h7
`define ATMI_DIR_WRITE 1'b0
`define ATMI_DIR_READ 1'b1
`define ATMI_MASTER_NACK 1'b1

// Register select codes carried in the command byte
`define ATMI_REG_CONFIG 2'h0
`define ATMI_REG_INPUT 2'h1
`define ATMI_REG_OUTPUT 2'h2
`define ATMI_REG_INVERT 2'h3
`define ATMI_CMD_PAD 6'h00

// Direction presets: low nibble drives attenuator, or all inputs for ID
`define ATMI_CFG_ATTEN 8'hf0
`define ATMI_CFG_ID 8'hff

// Byte framing
`define ATMI_LAST_BIT 3'h7

`endif

// [logic/atmi_pkg.sv]
// Types shared by the attenuator module host controller.
// Assumes atmi_defs.svh supplies the numeric constants.
package atmi_pkg;

  typedef enum logic [1:0] {
    op_wr,
    op_rd,
    op_cfg_atten,
    op_cfg_id
  } atmi_op_e;

  typedef struct packed {
    atmi_op_e op;
    logic [2:0] addr_lo;
    logic [1:0] reg_sel;
    logic [7:0] wdata;
  } atmi_cmd_s;

  typedef struct packed {
    logic nack;
    logic [7:0] rdata;
  } atmi_resp_s;

  typedef enum logic [1:0] {
    eng_start,
    eng_stop,
    eng_bit
  } atmi_eng_e;

  typedef enum logic [3:0] {
    st_idle,
    st_start,
    st_rstart,
    st_wbyte,
    st_wack,
    st_rbyte,
    st_mack,
    st_stop
  } atmi_state_e;

endpackage

// [logic/atmi_bit_engine.sv]
// Bit-level engine: start, stop and single data bits on the two-wire bus.
// Assumes pins are open drain with pull-ups; enables pull the line low.
`timescale 1ns/1ps
`default_nettype none
`include "atmi_defs.svh"
module atmi_bit_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Operation request
  input wire logic go,
  input wire atmi_pkg::atmi_eng_e op,
  input wire logic tx_bit,
  // Operation result
  output logic done,
  output logic rx_bit,
  output logic bus_idle,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe,
  output logic sda_oe
);

  logic scl_s1, scl_s2, sda_s1, sda_s2;
  logic busy;
  logic [1:0] ph;
  logic [6:0] qcnt;
  atmi_pkg::atmi_eng_e cur_op;
  logic tick;

  // Pins are asynchronous to clk
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end
    else
    begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
    end
  end

  assign bus_idle = scl_s2 & sda_s2;
  assign tick = busy && (qcnt == 7'(`ATMI_QUARTER_CYC - 1));

  // Quarter-period divider; four quarters make one bit period
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busy <= 1'b0;
      ph <= 2'h0;
      qcnt <= 7'h00;
      cur_op <= atmi_pkg::eng_start;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (go && !busy)
      begin
        busy <= 1'b1;
        ph <= 2'h0;
        qcnt <= 7'h00;
        cur_op <= op;
      end
      else if (tick)
      begin
        // A slave holding SCL low freezes the bit in its high phase
        if (ph == 2'h1 && !scl_s2)
          qcnt <= qcnt;
        else
        begin
          qcnt <= 7'h00;
          ph <= ph + 2'h1;
          if (ph == 2'h3)
          begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
      else if (busy)
        qcnt <= qcnt + 7'h01;
    end
  end

  // Line drive per phase; pull low or release only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rx_bit <= 1'b1;
    end
    else if (go && !busy)
    begin
      case (op)
        atmi_pkg::eng_start: sda_oe <= 1'b0;
        atmi_pkg::eng_stop: sda_oe <= 1'b1;
        // Data changes only while SCL is low
        atmi_pkg::eng_bit: sda_oe <= ~tx_bit;
        default: sda_oe <= 1'b0;
      endcase
    end
    else if (tick && !(ph == 2'h1 && !scl_s2))
    begin
      case (ph)
        2'h0: scl_oe <= 1'b0;
        2'h1:
        begin
          case (cur_op)
            atmi_pkg::eng_start: sda_oe <= 1'b1;
            atmi_pkg::eng_stop: sda_oe <= 1'b0;
            default: rx_bit <= sda_s2;
          endcase
        end
        2'h2:
          if (cur_op != atmi_pkg::eng_stop)
            scl_oe <= 1'b1;
        default: scl_oe <= scl_oe;
      endcase
    end
  end

endmodule
`default_nettype wire

// [logic/atmi_host.sv]
// Host controller that writes and reads the attenuator module port.
// Assumes one open-drain two-wire bus; testbench resolves wired-AND.
//
// What this block does
// - Lines are released when idle so both rest high.
// - Lines are only pulled low or released, never driven high.
// - Master clocks SCL at most 100 kbit/s, one pulse per bit.
// - Slave may hold SCL low; master waits before advancing.
// - Transmitter changes SDA only while SCL is low.
// - Start is SDA falling while SCL is high.
// - Stop is SDA rising while SCL is high.
// - Only the master issues start and stop.
// - Bus is busy from start until bus-free time after stop.
// - After an acked byte master sends or reads another byte, repeats start, or stops.
// - Reads use the same framing with master supplying clocks.
// - For attenuator use, low four bits outputs, upper four inputs.
// - Making all bits inputs lets the module-type ID be read.
`timescale 1ns/1ps
`default_nettype none
`include "atmi_defs.svh"
module atmi_host (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // User command port
  input wire logic cmd_valid,
  input wire atmi_pkg::atmi_cmd_s cmd,
  output logic cmd_ready,
  // User response port
  output logic resp_valid,
  output atmi_pkg::atmi_resp_s resp,
  // Clock line pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // Data line pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Status
  output logic xfer_busy
);

  atmi_pkg::atmi_state_e state;
  atmi_pkg::atmi_cmd_s cur;
  atmi_pkg::atmi_eng_e eng_op;
  logic [1:0] step;
  logic [2:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] cmd_b;
  logic [7:0] data_b;
  logic [7:0] free_cnt;
  logic go, tx_bit, done, rx_bit, bus_idle, nack, free_ok;

  // Address byte: fixed upper pattern, switch-selected low bits
  function automatic logic [7:0] addr_byte(input logic [2:0] lo,
                                           input logic dir);
    addr_byte = {`ATMI_ADDR_UPPER, lo, dir};
  endfunction

  // Register targeted by an operation
  function automatic logic [1:0] reg_of(input atmi_pkg::atmi_cmd_s c);
    case (c.op)
      atmi_pkg::op_cfg_atten: reg_of = `ATMI_REG_CONFIG;
      atmi_pkg::op_cfg_id: reg_of = `ATMI_REG_CONFIG;
      default: reg_of = c.reg_sel;
    endcase
  endfunction

  // Data byte written by an operation
  function automatic logic [7:0] data_of(input atmi_pkg::atmi_cmd_s c);
    case (c.op)
      atmi_pkg::op_cfg_atten: data_of = `ATMI_CFG_ATTEN;
      atmi_pkg::op_cfg_id: data_of = `ATMI_CFG_ID;
      default: data_of = c.wdata;
    endcase
  endfunction

  assign cmd_b = {`ATMI_CMD_PAD, reg_of(cur)};
  assign data_b = data_of(cur);
  assign free_ok = (free_cnt == 8'(`ATMI_BUS_FREE_CYC));

  atmi_bit_engine u_eng (
    .clk(clk),
    .sys_rst(sys_rst),
    .go(go),
    .op(eng_op),
    .tx_bit(tx_bit),
    .done(done),
    .rx_bit(rx_bit),
    .bus_idle(bus_idle),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );

  // Pin output levels are always low; only the enables move
  always_ff @(posedge clk)
  begin
    scl_o <= 1'b0;
    sda_o <= 1'b0;
  end

  // Bus-free timer: both lines high for the full interval
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      free_cnt <= 8'h00;
    else if (state != atmi_pkg::st_idle || !bus_idle)
      free_cnt <= 8'h00;
    else if (!free_ok)
      free_cnt <= free_cnt + 8'h01;
  end

  // Commands are taken only on a free, released bus
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cmd_ready <= 1'b0;
      xfer_busy <= 1'b0;
    end
    else
    begin
      cmd_ready <= (state == atmi_pkg::st_idle) && free_ok &&
                   !(cmd_valid && cmd_ready);
      xfer_busy <= (state != atmi_pkg::st_idle) || (cmd_valid && cmd_ready);
    end
  end

  // Answer after the closing stop
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      resp_valid <= 1'b0;
      resp <= '0;
    end
    else
    begin
      resp_valid <= 1'b0;
      if (state == atmi_pkg::st_stop && done)
      begin
        resp_valid <= 1'b1;
        resp.nack <= nack;
        resp.rdata <= (nack || cur.op != atmi_pkg::op_rd) ? 8'h00 : shreg;
      end
    end
  end

  // Transfer sequencer; only this side makes start and stop
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= atmi_pkg::st_idle;
      cur <= '0;
      eng_op <= atmi_pkg::eng_start;
      step <= 2'h0;
      bitcnt <= 3'h0;
      shreg <= 8'h00;
      tx_bit <= 1'b1;
      nack <= 1'b0;
      go <= 1'b0;
    end
    else
    begin
      go <= 1'b0;
      case (state)
        atmi_pkg::st_idle:
          if (cmd_valid && cmd_ready)
          begin
            cur <= cmd;
            nack <= 1'b0;
            step <= 2'h0;
            shreg <= addr_byte(cmd.addr_lo, `ATMI_DIR_WRITE);
            eng_op <= atmi_pkg::eng_start;
            go <= 1'b1;
            state <= atmi_pkg::st_start;
          end
        atmi_pkg::st_start, atmi_pkg::st_rstart:
          if (done)
          begin
            bitcnt <= 3'h0;
            eng_op <= atmi_pkg::eng_bit;
            tx_bit <= shreg[7];
            go <= 1'b1;
            state <= atmi_pkg::st_wbyte;
          end
        atmi_pkg::st_wbyte:
          if (done)
          begin
            go <= 1'b1;
            if (bitcnt == `ATMI_LAST_BIT)
            begin
              // Release SDA for the ninth clock
              tx_bit <= 1'b1;
              state <= atmi_pkg::st_wack;
            end
            else
            begin
              shreg <= {shreg[6:0], 1'b0};
              tx_bit <= shreg[6];
              bitcnt <= bitcnt + 3'h1;
            end
          end
        atmi_pkg::st_wack:
          if (done)
          begin
            go <= 1'b1;
            bitcnt <= 3'h0;
            if (rx_bit)
            begin
              // No acknowledge: wrong address or absent module
              nack <= 1'b1;
              eng_op <= atmi_pkg::eng_stop;
              state <= atmi_pkg::st_stop;
            end
            else
            begin
              case (step)
                2'h0:
                begin
                  shreg <= cmd_b;
                  tx_bit <= cmd_b[7];
                  step <= 2'h1;
                  state <= atmi_pkg::st_wbyte;
                end
                2'h1:
                  if (cur.op == atmi_pkg::op_rd)
                  begin
                    // Repeated start then read address
                    shreg <= addr_byte(cur.addr_lo, `ATMI_DIR_READ);
                    step <= 2'h3;
                    eng_op <= atmi_pkg::eng_start;
                    state <= atmi_pkg::st_rstart;
                  end
                  else
                  begin
                    shreg <= data_b;
                    tx_bit <= data_b[7];
                    step <= 2'h2;
                    state <= atmi_pkg::st_wbyte;
                  end
                2'h2:
                begin
                  eng_op <= atmi_pkg::eng_stop;
                  state <= atmi_pkg::st_stop;
                end
                default:
                begin
                  tx_bit <= 1'b1;
                  state <= atmi_pkg::st_rbyte;
                end
              endcase
            end
          end
        atmi_pkg::st_rbyte:
          if (done)
          begin
            go <= 1'b1;
            shreg <= {shreg[6:0], rx_bit};
            if (bitcnt == `ATMI_LAST_BIT)
            begin
              // Last byte of the read is not acknowledged
              tx_bit <= `ATMI_MASTER_NACK;
              state <= atmi_pkg::st_mack;
            end
            else
            begin
              tx_bit <= 1'b1;
              bitcnt <= bitcnt + 3'h1;
            end
          end
        atmi_pkg::st_mack:
          if (done)
          begin
            go <= 1'b1;
            eng_op <= atmi_pkg::eng_stop;
            state <= atmi_pkg::st_stop;
          end
        atmi_pkg::st_stop:
          if (done)
            state <= atmi_pkg::st_idle;
        default:
          state <= atmi_pkg::st_idle;
      endcase
    end
  end

endmodule
`default_nettype wire

// [tb/atmi_host_properties.sv]
// Port checker for the two-wire attenuator host controller.
// Assumes it is bound into atmi_host; bus inputs are wired-AND levels.
`timescale 1ns/1ps
`default_nettype none
`include "atmi_defs.svh"
module atmi_host_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // User side
  input wire logic cmd_valid,
  input wire atmi_pkg::atmi_cmd_s cmd,
  input wire logic cmd_ready,
  input wire logic resp_valid,
  input wire atmi_pkg::atmi_resp_s resp,
  input wire logic xfer_busy,
  // Bus pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe
);
  localparam int FREE = `ATMI_BUS_FREE_CYC;
  localparam int PER = 4 * `ATMI_QUARTER_CYC - 1;
  logic [8:0] free_cnt;
  logic [9:0] per_cnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Raw lines lead the synced copy, so this count never runs behind
  always_ff @(posedge clk)
  begin
    if (sys_rst || !scl_i || !sda_i)
      free_cnt <= 9'h000;
    else if (free_cnt != 9'h1ff)
      free_cnt <= free_cnt + 9'h001;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      per_cnt <= 10'h3ff;
    else if ($rose(scl_oe))
      per_cnt <= 10'h000;
    else if (per_cnt != 10'h3ff)
      per_cnt <= per_cnt + 10'h001;
  end
  a_pins_low_only: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  a_idle_released: assert property (cmd_ready |-> !scl_oe && !sda_oe)
    else $error("line held while idle");
  a_free_before_ready: assert property (cmd_ready |-> free_cnt >= FREE)
    else $error("ready before bus free");
  a_ready_not_busy: assert property (cmd_ready |-> !xfer_busy)
    else $error("ready while busy");
  a_take_holds_bus: assert property (
    cmd_valid && cmd_ready |=> !cmd_ready && xfer_busy)
    else $error("take not followed by busy");
  a_start_scl_high: assert property (
    $rose(sda_oe) && !scl_oe |-> scl_i)
    else $error("start with clock low");
  a_stop_scl_high: assert property (
    $fell(sda_oe) && !scl_oe |-> scl_i)
    else $error("stop with clock low");
  a_stop_then_idle: assert property (
    $fell(sda_oe) && !scl_oe |=> (!scl_oe && !sda_oe) [*8])
    else $error("activity right after stop");
  a_stretch_wait: assert property (
    !scl_oe && !scl_i |=> !scl_oe && $stable(sda_oe))
    else $error("advanced during stretch");
  a_clock_period: assert property ($rose(scl_oe) |-> per_cnt >= PER)
    else $error("clock too fast");
  c_done_ok: cover property (resp_valid && !resp.nack);
  c_done_nack: cover property (resp_valid && resp.nack);
  c_stretched: cover property (!scl_oe && !scl_i);
endmodule
bind atmi_host atmi_host_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp(resp),
  .xfer_busy(xfer_busy), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe)
);
`default_nettype wire

// [tb/atmi_dev_model.sv]
// Behavioural port expander of the attenuator module on the bus.
// Assumes the bench resolves wired-AND lines; clk far faster than SCL.
`timescale 1ns/1ps
`default_nettype none
`include "atmi_defs.svh"
module atmi_dev_model #(
  // Arbitrary value, stands for the module-type ID
  parameter logic [7:0] ID_PINS = 8'h5a
) (
  // Clock and bus levels
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  // Address switches; stretch is in pairs of clocks, to outlast three quarters
  input wire logic [2:0] sw,
  input wire logic [7:0] stretch,
  // High pulls the line low; never framing a transfer
  output logic scl_pull,
  output logic sda_pull
);
  logic ps = 1'b1;
  logic pd = 1'b1;
  logic tx = 1'b0;
  logic hit;
  logic [3:0] bc = 4'h0;
  logic [1:0] ph = 2'h3;
  logic [1:0] ptr = 2'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] ob = 8'h00;
  logic [8:0] st = 9'h000;
  logic [7:0] cfg = 8'hff;
  logic [7:0] outr = 8'h00;
  logic [7:0] inv = 8'h00;
  // Twins with equal switches answer alike
  assign hit = sh[7:1] == {`ATMI_ADDR_UPPER, sw};
  // A set config bit makes the pin an input
  function automatic logic [7:0] rd(input logic [1:0] p);
    case (p)
      `ATMI_REG_CONFIG: rd = cfg;
      `ATMI_REG_INPUT: rd = ((cfg & ID_PINS) | (~cfg & outr)) ^ inv;
      `ATMI_REG_OUTPUT: rd = outr;
      default: rd = inv;
    endcase
  endfunction
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  always @(posedge clk)
  begin
    ps <= scl;
    pd <= sda;
    if (st != 9'h000)
      st <= st - 9'h001;
    else
      scl_pull <= 1'b0;
    if (ps && scl && pd && !sda)
    begin
      ph <= 2'h0;
      bc <= 4'hf;
      tx <= 1'b0;
      sda_pull <= 1'b0;
    end
    else if (ps && scl && !pd && sda)
      ph <= 2'h3;
    else if (!ps && scl && ph != 2'h3)
    begin
      sh <= {sh[6:0], sda};
      if (bc == 4'h8 && tx && sda)
        ph <= 2'h3;
    end
    else if (ps && !scl && ph != 2'h3)
    begin
      if (stretch != 8'h00)
      begin
        scl_pull <= 1'b1;
        st <= {stretch, 1'b0};
      end
      // Data only moves just after SCL falls
      if (bc == 4'h7)
      begin
        bc <= 4'h8;
        sda_pull <= !tx && (ph != 2'h0 || hit);
        if (ph == 2'h0)
        begin
          tx <= sh[0] && hit;
          ob <= rd(ptr);
        end
        if (ph == 2'h0 && !hit)
          ph <= 2'h3;
        if (ph == 2'h1)
          ptr <= sh[1:0];
        if (ph == 2'h2 && ptr == `ATMI_REG_CONFIG)
          cfg <= sh;
        if (ph == 2'h2 && ptr == `ATMI_REG_OUTPUT)
          outr <= sh;
        if (ph == 2'h2 && ptr == `ATMI_REG_INVERT)
          inv <= sh;
      end
      else if (bc == 4'h8)
      begin
        bc <= 4'h0;
        sda_pull <= tx && !ob[7];
        if (!tx && ph != 2'h2)
          ph <= ph + 2'h1;
      end
      else
      begin
        bc <= bc + 4'h1;
        sda_pull <= tx && !ob[6];
        ob <= {ob[6:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// [tb/atmi_host_tb.sv]
// Self-checking bench for the two-wire attenuator host controller.
// Assumes the device model and checker are compiled ahead of it.
`timescale 1ns/1ps
`default_nettype none
`include "atmi_defs.svh"
module atmi_host_tb;
  // Arbitrary pin pattern shown as the module-type ID
  localparam logic [7:0] ID_PINS = 8'h5a;
  logic clk;
  logic sys_rst;
  logic cmd_valid;
  logic cmd_ready;
  logic resp_valid;
  logic xfer_busy;
  logic scl_o;
  logic sda_o;
  logic scl_oe;
  logic sda_oe;
  logic scl;
  logic sda;
  logic [7:0] stretch;
  wire [3:0] pull;
  atmi_pkg::atmi_cmd_s cmd;
  atmi_pkg::atmi_resp_s resp;
  atmi_pkg::atmi_resp_s got;
  int err_total = 0;
  int comparisons = 0;
  // Wired-AND lines with pull-ups
  assign scl = !((scl_oe && !scl_o) || pull[0] || pull[2]);
  assign sda = !((sda_oe && !sda_o) || pull[1] || pull[3]);
  atmi_host dut (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp(resp),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .xfer_busy(xfer_busy)
  );
  atmi_dev_model #(.ID_PINS(ID_PINS)) u_dev (
    .clk(clk), .scl(scl), .sda(sda), .sw(3'h4), .stretch(stretch),
    .scl_pull(pull[0]), .sda_pull(pull[1])
  );
  // Ganged twin at the same address
  atmi_dev_model #(.ID_PINS(ID_PINS)) u_twin (
    .clk(clk), .scl(scl), .sda(sda), .sw(3'h4), .stretch(8'h00),
    .scl_pull(pull[2]), .sda_pull(pull[3])
  );
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t byte %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t flag %b want %b", $time, g, e);
    end
  endtask
  task automatic step;
    @(posedge clk);
    #2;
  endtask
  task automatic run(input atmi_pkg::atmi_op_e op, input logic [1:0] sel,
    input logic [7:0] wd, input logic [2:0] lo);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000)
    begin
      step;
      n++;
    end
    chk1(cmd_ready, 1'b1);
    cmd_valid = 1'b1;
    cmd = {op, lo, sel, wd};
    step;
    chk1(xfer_busy, 1'b1);
    cmd_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 40000)
    begin
      step;
      n++;
    end
    chk1(resp_valid, 1'b1);
    got = resp;
  endtask
  task automatic t_reset;
    chk1(cmd_ready, 1'b0);
    chk1(scl_oe || sda_oe, 1'b0);
    run(atmi_pkg::op_rd, `ATMI_REG_INVERT, 8'h00, 3'h4);
    chk1(got.nack, 1'b0);
    chk8(got.rdata, 8'h00);
  endtask
  task automatic t_write;
    stretch = 8'hb4;
    run(atmi_pkg::op_wr, `ATMI_REG_OUTPUT, 8'h93, 3'h4);
    stretch = 8'h00;
    chk1(got.nack, 1'b0);
    chk8(u_dev.outr, 8'h93);
    chk8(u_twin.outr, 8'h93);
  endtask
  task automatic t_atten;
    run(atmi_pkg::op_cfg_atten, `ATMI_REG_CONFIG, 8'h00, 3'h4);
    chk8(u_dev.cfg, 8'hf0);
    run(atmi_pkg::op_rd, `ATMI_REG_INPUT, 8'h00, 3'h4);
    chk8(got.rdata, (8'hf0 & ID_PINS) | 8'h03);
  endtask
  task automatic t_ident;
    run(atmi_pkg::op_cfg_id, `ATMI_REG_CONFIG, 8'h00, 3'h4);
    chk8(u_dev.cfg, 8'hff);
    run(atmi_pkg::op_rd, `ATMI_REG_INPUT, 8'h00, 3'h4);
    chk8(got.rdata, ID_PINS);
  endtask
  task automatic t_bad_addr;
    run(atmi_pkg::op_rd, `ATMI_REG_CONFIG, 8'h00, 3'h3);
    chk1(got.nack, 1'b1);
    chk8(got.rdata, 8'h00);
  endtask
  initial
  begin
    repeat (99000) @(posedge clk);
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop;
  end
  initial
  begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    stretch = 8'h00;
    repeat (8) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    step;
    t_reset;
    t_write;
    t_atten;
    t_ident;
    t_bad_addr;
    report_and_stop;
  end
endmodule
`default_nettype wire
